/* File: rtl/loop_ctrl.sv */
// Readout loop controller: drives the shared loop lines and collects BCD digits over APB
`timescale 1ns/1ps
module loop_ctrl
    import loop_pkg::*;
#(
    parameter int MODULES = MAX_MODULES,
    parameter int DIGITS = DIGITS_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output loop_out_t loop_o,
    input wire loop_in_t loop_i
);
    // Refuse sizes the counters cannot hold
    initial begin
        if (MODULES < 1 || MODULES > MAX_MODULES) $error("MODULES out of range");
        if (DIGITS < 1 || DIGITS > 255) $error("DIGITS out of range");
    end

    ctl_state_t state_q, state_d;
    logic [31:0] ctrl_q;
    logic [7:0] digit_q, module_q;
    logic [7:0] timer_q;
    logic [31:0] data_q;
    logic valid_q, short_q, ovf_q, done_q;
    logic [$bits(loop_in_t)-1:0] sync1_q, sync2_q;
    loop_in_t lin;

    // Two-stage synchroniser for every loop input; only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (clk_en) begin
            sync1_q <= loop_i;
            sync2_q <= sync1_q;
        end
    end
    assign lin = loop_in_t'(sync2_q);

    // APB decode
    wire access = psel && penable;
    wire wr_ctrl = access && pwrite && (paddr == OFF_CTRL);
    wire wr_status = access && pwrite && (paddr == OFF_STATUS);
    wire rd_data = access && !pwrite && (paddr == OFF_DATA);
    wire mapped = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) || (paddr == OFF_DIGITS)
        || (paddr == OFF_DATA) || (paddr == OFF_INFO);
    wire start_req = wr_ctrl && pwdata[CTRL_START_BIT] && (state_q == ST_IDLE);
    wire timer_done = (timer_q == 8'h00);
    wire last_digit = (digit_q == 8'(DIGITS - 1));
    wire token_back = lin.last_token;
    // A digit is taken at the end of the settle wait unless the token came back
    wire sample = (state_q == ST_WAIT) && timer_done && !token_back;
    wire [31:0] status_w = {27'h0, done_q, ovf_q, short_q, valid_q, state_q != ST_IDLE};
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // Read mux is combinational so reads complete in the access cycle
    always_comb begin
        case (paddr)
            OFF_CTRL: prdata = ctrl_q;
            OFF_STATUS: prdata = status_w;
            OFF_DIGITS: prdata = {24'h0, 8'(DIGITS)};
            OFF_DATA: prdata = data_q;
            OFF_INFO: prdata = {24'h0, module_q};
            default: prdata = 32'h0;
        endcase
    end

    // Loop sequencer: prepare pulse, then advance strobes until token returns
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (start_req) state_d = ST_PREP;
            ST_PREP: if (timer_done) state_d = ST_WAIT;
            ST_WAIT: if (timer_done) state_d = token_back ? ST_IDLE : ST_HOLD;
            ST_HOLD: if (!valid_q) state_d = ST_PULSE;
            ST_PULSE: if (timer_done) state_d = ST_GAP;
            ST_GAP: if (timer_done) state_d = ST_WAIT;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            ctrl_q <= CTRL_RESET_VALUE;
            timer_q <= 8'h00;
        end else if (clk_en) begin
            state_q <= state_d;
            if (wr_ctrl) ctrl_q <= pwdata & 32'h0000_001E;
            if (state_d != state_q) timer_q <= 8'(STROBE_CYCLES - 1);
            else if (!timer_done) timer_q <= timer_q - 8'h01;
        end
    end

    // Capture a digit before each advance; the slave's digit is stable in hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= 32'h0;
            valid_q <= 1'b0;
            short_q <= 1'b0;
            ovf_q <= 1'b0;
            done_q <= 1'b0;
            digit_q <= 8'h00;
            module_q <= 8'h00;
        end else if (clk_en) begin
            if (sample) begin
                data_q <= {8'h0, digit_q, module_q, 4'h0, lin.data};
                short_q <= short_q | lin.short_record;
                ovf_q <= ovf_q | valid_q;
                valid_q <= 1'b1;
            end else if (rd_data) begin
                valid_q <= 1'b0;
            end
            if (state_q == ST_GAP && timer_done) begin
                digit_q <= last_digit ? 8'h00 : digit_q + 8'h01;
                if (last_digit && module_q != 8'(MODULES - 1)) module_q <= module_q + 8'h01;
            end
            if (start_req) begin
                digit_q <= 8'h00;
                module_q <= 8'h00;
                done_q <= 1'b0;
            end
            if (state_q == ST_WAIT && timer_done && token_back) done_q <= 1'b1;
            // Set wins over a clear in the same cycle so no event is lost
            if (wr_status && pwdata[STAT_SHORT_BIT] && !(sample && lin.short_record))
                short_q <= 1'b0;
            if (wr_status && pwdata[STAT_OVF_BIT] && !(sample && valid_q)) ovf_q <= 1'b0;
        end
    end

    // Loop outputs; gate and reset are the controller's own lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_o <= '0;
        end else if (clk_en) begin
            loop_o.prepare <= (state_d == ST_PREP);
            loop_o.advance <= (state_d == ST_PULSE);
            loop_o.first_token <= (state_d != ST_IDLE && state_d != ST_PREP);
            loop_o.gate_o <= ctrl_q[CTRL_GATE_BIT];
            loop_o.gate_oe <= ctrl_q[CTRL_GATE_BIT];
            loop_o.preset <= ctrl_q[CTRL_PRESET_BIT];
            loop_o.sys_reset_o <= ctrl_q[CTRL_RESET_BIT];
            loop_o.sys_reset_oe <= ctrl_q[CTRL_RESET_BIT];
            loop_o.in_charge <= ctrl_q[CTRL_CHARGE_BIT];
        end
    end

    // Assertions
    a_prep_one_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(loop_o.prepare) |-> loop_o.prepare [*2])
        else $error("prepare strobe too short");
    a_adv_needs_token: assert property (@(posedge pclk) disable iff (!presetn)
        loop_o.advance |-> loop_o.first_token)
        else $error("advance without token");
    a_no_adv_in_prep: assert property (@(posedge pclk) disable iff (!presetn)
        !(loop_o.advance && loop_o.prepare))
        else $error("advance during prepare");
    a_reset_oe_match: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && $rose(ctrl_q[CTRL_RESET_BIT]) |=> loop_o.sys_reset_oe)
        else $error("reset line not driven");
    a_gate_follows_reg: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> loop_o.gate_oe == $past(ctrl_q[CTRL_GATE_BIT]))
        else $error("gate line wrong");
    a_charge_follows: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> loop_o.in_charge == $past(ctrl_q[CTRL_CHARGE_BIT]))
        else $error("control line wrong");
    a_preset_follows: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en |=> loop_o.preset == $past(ctrl_q[CTRL_PRESET_BIT]))
        else $error("preset line wrong");
    a_done_sets_idle: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(done_q) |-> state_q == ST_IDLE)
        else $error("done without idle");
    // A strobe shorter than the module can see would skip a digit
    a_adv_strobe_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(loop_o.advance) |-> loop_o.advance [*8])
        else $error("advance strobe too short");
    a_hold_no_adv: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_HOLD |-> !loop_o.advance)
        else $error("advance before digit read");
    a_token_ends_round: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && state_q == ST_WAIT && timer_done && token_back |=> state_q == ST_IDLE)
        else $error("round kept after token");
    a_short_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        short_q && !wr_status |=> short_q)
        else $error("short flag lost");
    a_freeze_state: assert property (@(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(state_q))
        else $error("state moved while frozen");
    c_round: cover property (@(posedge pclk) $rose(done_q));
    c_advance: cover property (@(posedge pclk) $rose(loop_o.advance));
    c_digit: cover property (@(posedge pclk) $rose(valid_q));
    c_short: cover property (@(posedge pclk) $rose(short_q));
endmodule // loop_ctrl

/* File: include/loop_pkg.sv */
// Package for the readout loop controller: register map, pin carriers, timing constants
package loop_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DIGITS = 8'h08;
    localparam logic [7:0] OFF_DATA = 8'h0C;
    localparam logic [7:0] OFF_INFO = 8'h10;
    // Control register fields
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_GATE_BIT = 1;
    localparam int CTRL_PRESET_BIT = 2;
    localparam int CTRL_RESET_BIT = 3;
    localparam int CTRL_CHARGE_BIT = 4;
    localparam logic [31:0] CTRL_RESET_VALUE = 32'h0000_0000;
    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_SHORT_BIT = 2;
    localparam int STAT_OVF_BIT = 3;
    localparam int STAT_DONE_BIT = 4;
    // Data word fields
    localparam int DATA_MODULE_LSB = 8;
    localparam int DATA_DIGIT_LSB = 16;
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int STROBE_NS = 1000;
    localparam int STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MAX_MODULES = 50;
    localparam int DIGITS_DEFAULT = 16;
    localparam int DIGIT_W = 4;

    // Lines the controller drives into the loop
    typedef struct packed {
        logic prepare;
        logic advance;
        logic first_token;
        logic gate_o;
        logic gate_oe;
        logic preset;
        logic sys_reset_o;
        logic sys_reset_oe;
        logic in_charge;
    } loop_out_t;

    // Lines the loop returns to the controller
    typedef struct packed {
        logic [DIGIT_W-1:0] data;
        logic last_token;
        logic short_record;
        logic gate_i;
        logic sys_reset_i;
    } loop_in_t;

    typedef enum logic [2:0] {ST_IDLE, ST_PREP, ST_WAIT, ST_HOLD, ST_PULSE, ST_GAP} ctl_state_t;
endpackage

/* File: dv/loop_module_model.sv */
// Behavioural model of one counter module on the readout loop
`timescale 1ns/1ps
module loop_module_model
    import loop_pkg::*;
#(
    parameter int NDIG = 4,
    parameter logic [15:0] COUNT = 16'h9305
) (
    input wire loop_out_t loop_o,
    output loop_in_t loop_i
);
    logic [15:0] snap_q = 16'h0000;
    logic [3:0] last_d = 4'h0;
    logic done_q = 1'b0;
    int idx = 0;
    wire turn = loop_o.first_token && !done_q;
    wire [3:0] cur = snap_q[4*(NDIG-1-idx) +: 4];
    // Snapshot at round start so the shifted digits stay consistent
    always @(posedge loop_o.prepare) begin
        snap_q = COUNT;
        idx = 0;
        done_q = 1'b0;
    end
    // Step from the top digit down; finish after the last advance
    always @(posedge loop_o.advance) begin
        if (turn) begin
            if (idx == NDIG-1) done_q = 1'b1;
            else idx++;
        end
    end
    always @* if (turn) last_d = cur;
    // Released data shows the inverse so a stale digit cannot pass
    assign loop_i.data = turn ? cur : ~last_d;
    assign loop_i.short_record = turn && (NDIG != 6);
    assign loop_i.last_token = loop_o.first_token && done_q;
    // Follower never drives gate or reset; pulled low when idle
    // A standalone member would neither drive nor obey these lines
    assign loop_i.gate_i = loop_o.gate_oe & loop_o.gate_o;
    assign loop_i.sys_reset_i = loop_o.sys_reset_oe & loop_o.sys_reset_o;
endmodule // loop_module_model

/* File: dv/loop_ctrl_tb_top.sv */
// Testbench for the readout loop controller
`timescale 1ns/1ps
module loop_ctrl_tb_top;
    import loop_pkg::*;
    localparam int NDIG = 4;
    logic pclk = 1'b0;
    logic en = 1'b1;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    loop_out_t loop_o;
    loop_in_t loop_i;
    int errors = 0;
    int n_checks = 0;
    logic [3:0] exp_dig [NDIG] = '{4'h9, 4'h3, 4'h0, 4'h5};
    initial forever #12.5 pclk = ~pclk;
    // Enable is dropped once to show that a frozen block ignores writes
    loop_ctrl #(.DIGITS(NDIG)) i_dut (.pclk(pclk), .presetn(presetn), .clk_en(en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_o(loop_o), .loop_i(loop_i));
    loop_module_model #(.NDIG(NDIG), .COUNT(16'h9305)) i_mod (.loop_o(loop_o), .loop_i(loop_i));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Bounded poll of one status bit; the watchdog cuts a hang
    task automatic poll(input int b);
        rd = 32'h0;
        for (int i = 0; i < 4000 && rd[b] !== 1'b1; i++) apb(1'b0, OFF_STATUS, 32'h0);
    endtask
    initial begin
        #1ms;
        errors++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFF_CTRL, 32'h0);
        check("ctrl reset", rd, CTRL_RESET_VALUE);
        apb(1'b0, OFF_DIGITS, 32'h0);
        check("digits", rd, NDIG);
        apb(1'b0, 8'h1C, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        // The gate, preset, reset and charge lines each follow their own control bit and no other
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, OFF_CTRL, 32'h2 << k);
            // Lines are registered: look once they have settled, then realign
            @(negedge pclk);
            check("lines", {loop_o.in_charge, loop_o.sys_reset_o, loop_o.preset,
                loop_o.gate_o}, 32'h1 << k);
            @(posedge pclk);
        end
        apb(1'b1, OFF_CTRL, 32'h0);
        // A low enable freezes all state, so this write must not land
        en <= 1'b0;
        apb(1'b1, OFF_CTRL, 32'h2);
        apb(1'b0, OFF_CTRL, 32'h0);
        check("frozen ctrl", rd, 32'h0);
        @(negedge pclk);
        check("frozen gate", {31'h0, loop_o.gate_o}, 32'h0);
        @(posedge pclk);
        en <= 1'b1;
        apb(1'b1, OFF_CTRL, 32'h1);
        for (int d = 0; d < NDIG; d++) begin
            poll(STAT_VALID_BIT);
            check("short", {31'h0, rd[STAT_SHORT_BIT]}, 32'h1);
            apb(1'b0, OFF_DATA, 32'h0);
            check("digit", rd, {8'h00, 8'(d), 8'h00, 4'h0, exp_dig[d]});
            // A start while busy must not disturb the round
            if (d == 0) apb(1'b1, OFF_CTRL, 32'h1);
        end
        poll(STAT_DONE_BIT);
        check("done", {31'h0, rd[STAT_BUSY_BIT]}, 32'h0);
        check("ovf", {31'h0, rd[STAT_OVF_BIT]}, 32'h0);
        conclude();
    end
endmodule // loop_ctrl_tb_top
